// ---- rtl/scl_pkg.sv ----
// Register map, field layout, reset values and counts of the sensor control.
package scl_pkg;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [7:0] ADDR_PIN_CONTROL    = 8'h6B;
  localparam logic [7:0] ADDR_ENABLE_CONTROL = 8'h80;
  localparam logic [7:0] ADDR_LAMP_CONTROL   = 8'hCD;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int unsigned POWER_ON_BIT_POS     = 0;
  localparam int unsigned MEASURE_ENABLE_POS   = 1;
  localparam int unsigned WAIT_ENABLE_POS      = 3;
  localparam int unsigned MUX_START_POS        = 4;
  localparam int unsigned GP_INPUT_LEVEL_POS   = 0;
  localparam int unsigned GP_OUTPUT_LEVEL_POS  = 1;
  localparam int unsigned GP_INPUT_ENABLE_POS  = 2;
  localparam int unsigned GP_INVERT_POS        = 3;
  localparam int unsigned LAMP_ON_POS          = 7;
  localparam int unsigned LAMP_CODE_LSB        = 0;
  localparam int unsigned LAMP_CODE_W          = 7;

  // ************************************************************
  // Values after reset
  // ************************************************************
  localparam logic       RST_POWER_ON        = 1'h0;
  localparam logic       RST_MEASURE_ENABLE  = 1'h0;
  localparam logic       RST_WAIT_ENABLE     = 1'h0;
  localparam logic       RST_MUX_START       = 1'h0;
  localparam logic       RST_GP_INVERT       = 1'h0;
  localparam logic       RST_GP_INPUT_ENABLE = 1'h0;
  localparam logic       RST_GP_OUTPUT_LEVEL = 1'h1;
  localparam logic       RST_LAMP_ON         = 1'h0;
  localparam logic [6:0] RST_LAMP_CODE       = 7'h04;

  // ************************************************************
  // Lamp current scale in mA
  // ************************************************************
  localparam logic [8:0] LAMP_BASE_MA = 9'h004;

  // ************************************************************
  // Cycle and tick counts
  // ************************************************************
  localparam int unsigned TICK_DIV   = 4;
  localparam int unsigned MEAS_TICKS = 16;
  localparam int unsigned WAIT_TICKS = 8;
  localparam int unsigned MUX_TICKS  = 4;

  typedef enum logic [1:0] {
    SCL_MEAS_IDLE,
    SCL_MEAS_INTEG,
    SCL_MEAS_WAIT
  } scl_meas_state_t;

endpackage

// ---- rtl/scl_mux_if.sv ----
// Handshake between the register bank and the multiplexer sequencer.
`timescale 1ns/100ps
interface scl_mux_if;
  logic tick;
  logic start;
  logic busy;
  logic done;

  modport seq  (input tick, input start, output busy, output done);
  modport ctrl (output tick, output start, input busy, input done);
endinterface

// ---- rtl/scl_mux_seq.sv ----
// Sensor multiplexer command sequencer, paced by the oscillator tick.
`timescale 1ns/100ps
module scl_mux_seq #(
  parameter int unsigned MUX_TICKS = scl_pkg::MUX_TICKS
) (
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic sys_rst_i,
  // Command handshake
  scl_mux_if.seq    mux
);

  localparam int unsigned CW = (MUX_TICKS > 1) ? $clog2(MUX_TICKS) : 1;
  localparam logic [CW-1:0] LAST = CW'(MUX_TICKS - 1);

  logic [CW-1:0] count;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      mux.busy <= 1'b0;
      mux.done <= 1'b0;
      count    <= '0;
    end else begin
      mux.done <= 1'b0;
      if (mux.start) begin
        mux.busy <= 1'b1;
        count    <= '0;
      end else if (mux.busy && mux.tick) begin
        if (count == LAST) begin
          mux.busy <= 1'b0;
          mux.done <= 1'b1;
        end else begin
          count <= count + 1'b1;
        end
      end
    end
  end

endmodule

// ---- rtl/scl_gp_pin.sv ----
// General-purpose pin: drive with optional inversion, or sample as input.
`timescale 1ns/100ps
module scl_gp_pin (
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic sys_rst_i,
  // Control fields
  input  wire logic invert_i,
  input  wire logic input_enable_i,
  input  wire logic output_level_i,
  // Pin
  input  wire logic pin_i,
  output logic      pin_o,
  output logic      pin_oe_n_o,
  // Sampled level
  output logic      input_level_o
);

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      pin_o      <= scl_pkg::RST_GP_OUTPUT_LEVEL ^ scl_pkg::RST_GP_INVERT;
      pin_oe_n_o <= scl_pkg::RST_GP_INPUT_ENABLE;
    end else begin
      pin_o      <= output_level_i ^ invert_i;
      pin_oe_n_o <= input_enable_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      input_level_o <= 1'b0;
    end else begin
      input_level_o <= input_enable_i & pin_i;
    end
  end

endmodule

// ---- rtl/scl_top.sv ----
// Enable, pin and lamp control registers of the spectral sensor.
`timescale 1ns/100ps

module scl_top #(
  parameter int unsigned TICK_DIV   = scl_pkg::TICK_DIV,
  parameter int unsigned MEAS_TICKS = scl_pkg::MEAS_TICKS,
  parameter int unsigned WAIT_TICKS = scl_pkg::WAIT_TICKS,
  parameter int unsigned MUX_TICKS  = scl_pkg::MUX_TICKS
) (
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       sys_rst_i,
  // Register port
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  // Oscillator and measurement status
  output logic            osc_en_o,
  output logic            meas_active_o,
  output logic            meas_wait_o,
  output logic            meas_done_o,
  output logic            mux_busy_o,
  // General-purpose pin
  input  wire logic       gp_pin_i,
  output logic            gp_pin_o,
  output logic            gp_pin_oe_n_o,
  // Lamp driver
  output logic            lamp_drive_pin_o,
  output logic      [6:0] lamp_current_code_o,
  output logic      [8:0] lamp_current_ma_o
);

  localparam int unsigned DW = (TICK_DIV > 1) ? $clog2(TICK_DIV) : 1;
  localparam int unsigned MW = $clog2(MEAS_TICKS + WAIT_TICKS + 1);
  localparam logic [DW-1:0] DIV_LAST  = DW'(TICK_DIV - 1);
  localparam logic [MW-1:0] MEAS_LAST = MW'(MEAS_TICKS - 1);
  localparam logic [MW-1:0] WAIT_LAST = MW'(WAIT_TICKS - 1);

  // ************************************************************
  // Register state
  // ************************************************************
  logic       power_on_bit;
  logic       spectral_measure_enable;
  logic       measurement_wait_enable;
  logic       sensor_mux_start;
  logic       gp_pin_invert;
  logic       gp_pin_input_enable;
  logic       gp_pin_output_level;
  logic       gp_pin_input_level;
  logic       lamp_on;
  logic [6:0] lamp_drive_current;

  logic       wr_enable;
  logic       wr_pin;
  logic       wr_lamp;
  logic       tick;
  logic [DW-1:0] div_count;
  logic [MW-1:0] meas_count;
  scl_pkg::scl_meas_state_t meas_state;
  scl_pkg::scl_meas_state_t next_meas_state;
  logic [8:0] next_lamp_ma;

  scl_mux_if mux ();

  // Address match shared by the write and read paths
  function automatic logic addr_hit(input logic [7:0] addr,
                                    input logic [7:0] target);
    addr_hit = (addr == target);
  endfunction

  assign wr_enable = reg_wr_i && addr_hit(reg_addr_i,
                                          scl_pkg::ADDR_ENABLE_CONTROL);
  assign wr_pin    = reg_wr_i && addr_hit(reg_addr_i,
                                          scl_pkg::ADDR_PIN_CONTROL);
  assign wr_lamp   = reg_wr_i && addr_hit(reg_addr_i,
                                          scl_pkg::ADDR_LAMP_CONTROL);

  // ************************************************************
  // Enable register
  // ************************************************************
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      power_on_bit            <= scl_pkg::RST_POWER_ON;
      spectral_measure_enable <= scl_pkg::RST_MEASURE_ENABLE;
      measurement_wait_enable <= scl_pkg::RST_WAIT_ENABLE;
    end else if (wr_enable) begin
      power_on_bit            <= reg_wdata_i[scl_pkg::POWER_ON_BIT_POS];
      spectral_measure_enable <= reg_wdata_i[scl_pkg::MEASURE_ENABLE_POS];
      measurement_wait_enable <= reg_wdata_i[scl_pkg::WAIT_ENABLE_POS];
    end
  end

  // Self-clearing start; a new write of one wins over completion
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      sensor_mux_start <= scl_pkg::RST_MUX_START;
    end else if (wr_enable && reg_wdata_i[scl_pkg::MUX_START_POS]) begin
      sensor_mux_start <= 1'b1;
    end else if (mux.done) begin
      sensor_mux_start <= 1'b0;
    end
  end

  // Launch only when no command is pending or one ends now
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      mux.start <= 1'b0;
    end else begin
      mux.start <= wr_enable && reg_wdata_i[scl_pkg::MUX_START_POS]
                   && (!sensor_mux_start || mux.done);
    end
  end

  // ************************************************************
  // Pin and lamp registers
  // ************************************************************
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      gp_pin_invert       <= scl_pkg::RST_GP_INVERT;
      gp_pin_input_enable <= scl_pkg::RST_GP_INPUT_ENABLE;
      gp_pin_output_level <= scl_pkg::RST_GP_OUTPUT_LEVEL;
    end else if (wr_pin) begin
      gp_pin_invert       <= reg_wdata_i[scl_pkg::GP_INVERT_POS];
      gp_pin_input_enable <= reg_wdata_i[scl_pkg::GP_INPUT_ENABLE_POS];
      gp_pin_output_level <= reg_wdata_i[scl_pkg::GP_OUTPUT_LEVEL_POS];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      lamp_on            <= scl_pkg::RST_LAMP_ON;
      lamp_drive_current <= scl_pkg::RST_LAMP_CODE;
    end else if (wr_lamp) begin
      lamp_on            <= reg_wdata_i[scl_pkg::LAMP_ON_POS];
      lamp_drive_current <= reg_wdata_i[scl_pkg::LAMP_CODE_LSB +:
                                        scl_pkg::LAMP_CODE_W];
    end
  end

  // ************************************************************
  // Read port
  // ************************************************************
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= 8'h00;
      if (addr_hit(reg_addr_i, scl_pkg::ADDR_ENABLE_CONTROL)) begin
        reg_rdata_o[scl_pkg::POWER_ON_BIT_POS]   <= power_on_bit;
        reg_rdata_o[scl_pkg::MEASURE_ENABLE_POS] <= spectral_measure_enable;
        reg_rdata_o[scl_pkg::WAIT_ENABLE_POS]    <= measurement_wait_enable;
        reg_rdata_o[scl_pkg::MUX_START_POS]      <= sensor_mux_start;
      end else if (addr_hit(reg_addr_i, scl_pkg::ADDR_PIN_CONTROL)) begin
        reg_rdata_o[scl_pkg::GP_INVERT_POS]       <= gp_pin_invert;
        reg_rdata_o[scl_pkg::GP_INPUT_ENABLE_POS] <= gp_pin_input_enable;
        reg_rdata_o[scl_pkg::GP_OUTPUT_LEVEL_POS] <= gp_pin_output_level;
        reg_rdata_o[scl_pkg::GP_INPUT_LEVEL_POS]  <= gp_pin_input_level;
      end else if (addr_hit(reg_addr_i, scl_pkg::ADDR_LAMP_CONTROL)) begin
        reg_rdata_o[scl_pkg::LAMP_ON_POS] <= lamp_on;
        reg_rdata_o[scl_pkg::LAMP_CODE_LSB +: scl_pkg::LAMP_CODE_W]
          <= lamp_drive_current;
      end
    end
  end

  // ************************************************************
  // Oscillator tick divider
  // ************************************************************
  assign osc_en_o = power_on_bit;
  assign tick     = power_on_bit && (div_count == DIV_LAST);

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || !power_on_bit) begin
      div_count <= '0;
    end else if (div_count == DIV_LAST) begin
      div_count <= '0;
    end else begin
      div_count <= div_count + 1'b1;
    end
  end

  assign mux.tick   = tick;
  assign mux_busy_o = mux.busy;

  scl_mux_seq #(
    .MUX_TICKS (MUX_TICKS)
  ) u_mux_seq (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .mux       (mux.seq)
  );

  // ************************************************************
  // Measurement sequencer
  // ************************************************************
  always_comb begin
    next_meas_state = meas_state;
    unique case (meas_state)
      scl_pkg::SCL_MEAS_IDLE: begin
        if (!sensor_mux_start && !mux.busy) begin
          next_meas_state = scl_pkg::SCL_MEAS_INTEG;
        end
      end
      scl_pkg::SCL_MEAS_INTEG: begin
        if (tick && meas_count == MEAS_LAST) begin
          next_meas_state = measurement_wait_enable
                            ? scl_pkg::SCL_MEAS_WAIT
                            : scl_pkg::SCL_MEAS_INTEG;
        end
      end
      scl_pkg::SCL_MEAS_WAIT: begin
        if (tick && meas_count == WAIT_LAST) begin
          next_meas_state = scl_pkg::SCL_MEAS_INTEG;
        end
      end
    endcase
    if (!spectral_measure_enable || !power_on_bit) begin
      next_meas_state = scl_pkg::SCL_MEAS_IDLE;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      meas_state <= scl_pkg::SCL_MEAS_IDLE;
    end else begin
      meas_state <= next_meas_state;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || next_meas_state != meas_state) begin
      meas_count <= '0;
    end else if (tick && meas_state == scl_pkg::SCL_MEAS_INTEG
                 && meas_count == MEAS_LAST) begin
      meas_count <= '0;
    end else if (tick && meas_state != scl_pkg::SCL_MEAS_IDLE) begin
      meas_count <= meas_count + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      meas_done_o   <= 1'b0;
      meas_active_o <= 1'b0;
      meas_wait_o   <= 1'b0;
    end else begin
      meas_done_o   <= tick && meas_state == scl_pkg::SCL_MEAS_INTEG
                       && meas_count == MEAS_LAST
                       && spectral_measure_enable && power_on_bit;
      meas_active_o <= next_meas_state == scl_pkg::SCL_MEAS_INTEG;
      meas_wait_o   <= next_meas_state == scl_pkg::SCL_MEAS_WAIT;
    end
  end

  // ************************************************************
  // Pin and lamp drive
  // ************************************************************
  scl_gp_pin u_gp_pin (
    .sys_clk_i      (sys_clk_i),
    .sys_rst_i      (sys_rst_i),
    .invert_i       (gp_pin_invert),
    .input_enable_i (gp_pin_input_enable),
    .output_level_i (gp_pin_output_level),
    .pin_i          (gp_pin_i),
    .pin_o          (gp_pin_o),
    .pin_oe_n_o     (gp_pin_oe_n_o),
    .input_level_o  (gp_pin_input_level)
  );

  assign next_lamp_ma = 9'(scl_pkg::LAMP_BASE_MA
                           + {1'b0, lamp_drive_current, 1'b0});

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      lamp_drive_pin_o    <= scl_pkg::RST_LAMP_ON;
      lamp_current_code_o <= scl_pkg::RST_LAMP_CODE;
      lamp_current_ma_o   <= 9'(scl_pkg::LAMP_BASE_MA
                                + {1'b0, scl_pkg::RST_LAMP_CODE, 1'b0});
    end else begin
      lamp_drive_pin_o    <= lamp_on;
      lamp_current_code_o <= lamp_drive_current;
      lamp_current_ma_o   <= next_lamp_ma;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  osc_tick_gate_a : assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    !power_on_bit |-> !tick && osc_en_o == 1'b0
    && (!mux.done || $past(power_on_bit)))
    else $error("tick seen while powered off");

  mux_launch_a : assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    wr_enable && reg_wdata_i[scl_pkg::MUX_START_POS] && !sensor_mux_start
    |=> mux.start ##1 mux.busy && sensor_mux_start)
    else $error("mux command not launched");

  mux_self_clear_a : assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    mux.done && !(wr_enable && reg_wdata_i[scl_pkg::MUX_START_POS])
    |=> !sensor_mux_start)
    else $error("mux start bit not cleared");

  wait_insert_a : assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    meas_done_o && $past(measurement_wait_enable)
    && spectral_measure_enable && power_on_bit
    |-> meas_state == scl_pkg::SCL_MEAS_WAIT)
    else $error("wait period missing");

  wait_skip_a : assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    meas_done_o && !$past(measurement_wait_enable)
    |-> meas_state != scl_pkg::SCL_MEAS_WAIT)
    else $error("unexpected wait period");

  meas_stop_a : assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    !spectral_measure_enable |=> meas_state == scl_pkg::SCL_MEAS_IDLE
    && !meas_active_o)
    else $error("measurement runs while disabled");

  pin_polarity_a : assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    !gp_pin_input_enable && $stable(gp_pin_invert)
    && $stable(gp_pin_output_level)
    |=> gp_pin_o == ($past(gp_pin_output_level) ^ $past(gp_pin_invert))
        && !gp_pin_oe_n_o)
    else $error("pin output level wrong");

  pin_input_a : assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    gp_pin_input_enable |=> gp_pin_oe_n_o)
    else $error("pin driven while input enabled");

  pin_status_a : assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    reg_rd_i && addr_hit(reg_addr_i, scl_pkg::ADDR_PIN_CONTROL)
    && !gp_pin_input_enable && !$past(gp_pin_input_enable)
    |=> !reg_rdata_o[scl_pkg::GP_INPUT_LEVEL_POS])
    else $error("input level shown while disabled");

  lamp_switch_a : assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    wr_lamp |=> ##1 lamp_drive_pin_o == $past(reg_wdata_i[7], 2))
    else $error("lamp pin does not follow lamp-on");

  lamp_current_a : assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    wr_lamp |=> ##1 lamp_current_ma_o
      == 9'(9'h004 + 9'h002 * {2'h0, $past(reg_wdata_i[6:0], 2)}))
    else $error("lamp current scale wrong");

  reserved_zero_a : assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    reg_rd_i && addr_hit(reg_addr_i, scl_pkg::ADDR_ENABLE_CONTROL)
    |=> reg_rdata_o[7:5] == 3'h0 && reg_rdata_o[2] == 1'b0)
    else $error("reserved bits read non-zero");

endmodule

// ---- dv/scl_pin_lamp_model.sv ----
// Model of the external pin circuit and lamp hooked to the sensor control.
`timescale 1ns/100ps
module scl_pin_lamp_model (
  // Clock
  input  wire logic       sys_clk_i,
  // Pin side
  input  wire logic       gp_pin_o,
  input  wire logic       gp_pin_oe_n_o,
  input  wire logic       ext_drive_i,
  input  wire logic       ext_level_i,
  output logic            gp_pin_i,
  // Lamp side
  input  wire logic       lamp_drive_pin_o,
  input  wire logic [8:0] lamp_current_ma_o,
  output logic      [8:0] lamp_ma_seen_o
);
  logic last_level;

  initial last_level = 1'h0;

  // Device drives when enable low, else the outside circuit; floating toggles
  always_comb begin
    if (!gp_pin_oe_n_o) begin
      gp_pin_i = gp_pin_o;
    end else if (ext_drive_i) begin
      gp_pin_i = ext_level_i;
    end else begin
      gp_pin_i = ~last_level;
    end
  end

  always @(posedge sys_clk_i) begin
    last_level <= gp_pin_i;
  end

  // Lamp draws current only while switched on
  assign lamp_ma_seen_o = lamp_drive_pin_o ? lamp_current_ma_o : 9'h000;
endmodule

// ---- dv/sensor_enable_pin_lamp_ctrl_bench.sv ----
// Self-checking bench of the enable, pin and lamp control registers.
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin \
  error_cnt++; $display("BAD %s exp %h got %h", nm, exp, got); end end
module sensor_enable_pin_lamp_ctrl_bench;
  localparam int unsigned DIV = 2;
  localparam int unsigned MEAS = 4;
  localparam int unsigned WAITT = 3;
  localparam int unsigned MUXT = 2;
  logic       sys_clk_i = 1'h0;
  logic       sys_rst_i = 1'h1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic       reg_wr_i = 1'h0;
  logic       reg_rd_i = 1'h0;
  logic [7:0] reg_rdata_o;
  logic       osc_en_o, meas_active_o, meas_wait_o, meas_done_o, mux_busy_o;
  logic       gp_pin_i, gp_pin_o, gp_pin_oe_n_o, lamp_drive_pin_o;
  logic [6:0] lamp_current_code_o;
  logic [8:0] lamp_current_ma_o, lamp_ma_seen;
  logic       ext_drive = 1'h0;
  logic       ext_level = 1'h0;
  int         error_cnt = 0;
  int         n_checks = 0;

  scl_top #(.TICK_DIV(DIV), .MEAS_TICKS(MEAS), .WAIT_TICKS(WAITT),
            .MUX_TICKS(MUXT)) uut (.sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .osc_en_o(osc_en_o),
    .meas_active_o(meas_active_o), .meas_wait_o(meas_wait_o),
    .meas_done_o(meas_done_o), .mux_busy_o(mux_busy_o),
    .gp_pin_i(gp_pin_i), .gp_pin_o(gp_pin_o),
    .gp_pin_oe_n_o(gp_pin_oe_n_o),
    .lamp_drive_pin_o(lamp_drive_pin_o),
    .lamp_current_code_o(lamp_current_code_o),
    .lamp_current_ma_o(lamp_current_ma_o));
  scl_pin_lamp_model model (.sys_clk_i(sys_clk_i), .gp_pin_o(gp_pin_o),
    .gp_pin_oe_n_o(gp_pin_oe_n_o), .ext_drive_i(ext_drive),
    .ext_level_i(ext_level), .gp_pin_i(gp_pin_i),
    .lamp_drive_pin_o(lamp_drive_pin_o),
    .lamp_current_ma_o(lamp_current_ma_o), .lamp_ma_seen_o(lamp_ma_seen));

  always #5 sys_clk_i = ~sys_clk_i;

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_wr_i <= 1'h1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'h0;
  endtask

  task automatic reg_check(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk_i);
    reg_rd_i <= 1'h1;
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'h0;
    #1;
    `CHK("read data", exp, reg_rdata_o)
  endtask

  function automatic logic pick(input int sel);
    case (sel)
      0: pick = meas_active_o;
      1: pick = meas_wait_o;
      2: pick = meas_done_o;
      default: pick = mux_busy_o;
    endcase
  endfunction

  // Bounded wait for a status output to reach a level
  task automatic wait_on(input int sel, input logic v, input int lim);
    int i;
    i = 0;
    while (pick(sel) !== v && i < lim) begin
      @(posedge sys_clk_i);
      #1;
      i++;
    end
    `CHK("status wait", v, pick(sel))
  endtask

  task automatic test_reset_values;
    reg_check(scl_pkg::ADDR_PIN_CONTROL, 8'h02);
    reg_check(scl_pkg::ADDR_ENABLE_CONTROL, 8'h00);
    reg_check(scl_pkg::ADDR_LAMP_CONTROL, 8'h04);
    reg_check(8'h81, 8'h00);
    `CHK("osc", 1'h0, osc_en_o)
    `CHK("pin drive", 1'h1, gp_pin_o)
    `CHK("lamp", 1'h0, lamp_drive_pin_o)
    `CHK("lamp ma", 9'h00C, lamp_current_ma_o)
  endtask

  task automatic test_lamp;
    reg_write(scl_pkg::ADDR_LAMP_CONTROL, 8'h85);
    @(posedge sys_clk_i);
    #1;
    `CHK("lamp on", 1'h1, lamp_drive_pin_o)
    `CHK("lamp code", 7'h05, lamp_current_code_o)
    `CHK("lamp seen", 9'h00E, lamp_ma_seen)
    reg_write(scl_pkg::ADDR_LAMP_CONTROL, 8'hFF);
    @(posedge sys_clk_i);
    #1;
    `CHK("lamp max", 9'h102, lamp_current_ma_o)
    reg_write(scl_pkg::ADDR_LAMP_CONTROL, 8'h00);
    @(posedge sys_clk_i);
    #1;
    `CHK("lamp off", 1'h0, lamp_drive_pin_o)
    `CHK("lamp min", 9'h004, lamp_current_ma_o)
    reg_check(scl_pkg::ADDR_LAMP_CONTROL, 8'h00);
  endtask

  task automatic test_gp_pin;
    reg_write(scl_pkg::ADDR_PIN_CONTROL, 8'hFA);
    reg_check(scl_pkg::ADDR_PIN_CONTROL, 8'h0A);
    `CHK("inverted", 1'h0, gp_pin_o)
    `CHK("driving", 1'h0, gp_pin_oe_n_o)
    reg_write(scl_pkg::ADDR_PIN_CONTROL, 8'h08);
    @(posedge sys_clk_i);
    #1;
    `CHK("level low inverted", 1'h1, gp_pin_o)
    @(posedge sys_clk_i);
    ext_drive <= 1'h1;
    ext_level <= 1'h1;
    reg_write(scl_pkg::ADDR_PIN_CONTROL, 8'h04);
    @(posedge sys_clk_i);
    #1;
    `CHK("released", 1'h1, gp_pin_oe_n_o)
    reg_check(scl_pkg::ADDR_PIN_CONTROL, 8'h05);
    @(posedge sys_clk_i);
    ext_level <= 1'h0;
    repeat (3) @(posedge sys_clk_i);
    reg_check(scl_pkg::ADDR_PIN_CONTROL, 8'h04);
    reg_write(scl_pkg::ADDR_PIN_CONTROL, 8'h02);
    ext_drive <= 1'h0;
    repeat (3) @(posedge sys_clk_i);
    reg_check(scl_pkg::ADDR_PIN_CONTROL, 8'h02);
  endtask

  task automatic test_enable;
    reg_write(scl_pkg::ADDR_ENABLE_CONTROL, 8'hE5);
    reg_check(scl_pkg::ADDR_ENABLE_CONTROL, 8'h01);
    `CHK("osc on", 1'h1, osc_en_o)
    reg_write(scl_pkg::ADDR_ENABLE_CONTROL, 8'h11);
    wait_on(3, 1'h1, 4);
    wait_on(3, 1'h0, MUXT * DIV + 8);
    reg_check(scl_pkg::ADDR_ENABLE_CONTROL, 8'h01);
    reg_write(scl_pkg::ADDR_ENABLE_CONTROL, 8'h03);
    wait_on(0, 1'h1, 8);
    wait_on(2, 1'h1, MEAS * DIV + 8);
    wait_on(0, 1'h1, 3);
    `CHK("no wait", 1'h0, meas_wait_o)
    reg_write(scl_pkg::ADDR_ENABLE_CONTROL, 8'h09);
    reg_write(scl_pkg::ADDR_ENABLE_CONTROL, 8'h0B);
    wait_on(2, 1'h1, MEAS * DIV + 8);
    wait_on(1, 1'h1, 3);
    `CHK("idle in wait", 1'h0, meas_active_o)
    wait_on(0, 1'h1, WAITT * DIV + 8);
    reg_write(scl_pkg::ADDR_ENABLE_CONTROL, 8'h00);
    @(posedge sys_clk_i);
    #1;
    `CHK("osc off", 1'h0, osc_en_o)
    `CHK("stopped", 1'h0, meas_active_o)
  endtask

  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge sys_clk_i);
    `CHK("reset pin drive", 1'h1, gp_pin_o)
    sys_rst_i <= 1'h0;
    test_reset_values();
    test_lamp();
    test_gp_pin();
    test_enable();
    complete_run();
  end

  initial begin
    #200000;
    error_cnt++;
    complete_run();
  end
endmodule
